// ===== include/uecs_consts.svh
`ifndef UECS_CONSTS_SVH
`define UECS_CONSTS_SVH

// register offsets (byte addresses on the plain port)
`define UECS_ADDR_W        8
`define UECS_OFS_CSR       8'h00
`define UECS_OFS_FDR       8'h04
`define UECS_OFS_TXVC      8'h08

// control/status, data and transceiver register field positions
`define UECS_B_SETUP       2
`define UECS_B_HALTACK     3
`define UECS_B_FORCE       5
`define UECS_B_BK1         6
`define UECS_B_DIR         7
`define UECS_B_TYPE_LO     8
`define UECS_B_TYPE_HI     10
`define UECS_B_TOGGLE      11
`define UECS_B_ENABLE      15
`define UECS_B_CNT_LO      16
`define UECS_B_CNT_HI      26
`define UECS_B_FDATA_HI    7
`define UECS_B_XOFF        8

// endpoint type codes
`define UECS_TYPE_CTRL     3'h0
`define UECS_TYPE_ISO_OUT  3'h1
`define UECS_TYPE_ISO_IN   3'h5
`define UECS_TYPE_BULK_OUT 3'h2
`define UECS_TYPE_BULK_IN  3'h6
`define UECS_TYPE_INT_OUT  3'h3
`define UECS_TYPE_INT_IN   3'h7

// reset values
`define UECS_RST_BIT       1'h0
`define UECS_RST_TYPE      3'h0
`define UECS_RST_DATA      32'h0000_0000

// fifo geometry
`define UECS_FIFO_DEPTH    64
`define UECS_PTR_W         6
`define UECS_CNT_W         11
`define UECS_PTR_ONE       6'h01
`define UECS_CNT_ONE       11'h001
`define UECS_CNT_FULL      11'h040

// bus reset detection on a held single-ended zero
`define UECS_CLK_NS        25
`define UECS_T_SE0_NS      2500
`define UECS_SE0_CYC       ((`UECS_T_SE0_NS + `UECS_CLK_NS - 1) / `UECS_CLK_NS)
`define UECS_SE0_W         7

`endif

// ===== include/uecs_pkg.sv
`include "uecs_consts.svh"

package uecs_pkg;

	typedef enum logic [2:0] {
		UECS_CTRL     = 3'h0,
		UECS_ISO_OUT  = 3'h1,
		UECS_BULK_OUT = 3'h2,
		UECS_INT_OUT  = 3'h3,
		UECS_ISO_IN   = 3'h5,
		UECS_BULK_IN  = 3'h6,
		UECS_INT_IN   = 3'h7
	} uecs_type_e;

	// events from the packet engine
	typedef struct packed {
		logic       setup_ok;
		logic       bk1_stored;
		logic       stall_acked;
		logic       toggle_upd;
		logic       toggle_val;
		logic       data_stage;
		logic       status_stage;
		logic       rx_valid;
		logic [7:0] rx_byte;
		logic       tx_pop;
	} uecs_evt_s;

	// answers to the packet engine
	typedef struct packed {
		logic send_stall;
		logic stall_halted;
		logic out_accept;
		logic in_allowed;
		logic stage_dir_in;
		logic ep_active;
	} uecs_rsp_s;

endpackage : uecs_pkg

// ===== rtl/uecs_byte_fifo.sv
`timescale 1ns/1ps
`include "uecs_consts.svh"

module uecs_byte_fifo (
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	// flush
	input  wire logic                   clr,
	// fill side
	input  wire logic                   push,
	input  wire logic [7:0]             push_data,
	// drain side
	input  wire logic                   pop,
	output logic      [7:0]             head,
	// state
	output logic      [`UECS_CNT_W-1:0] count,
	output logic                        full,
	output logic                        empty
);

	logic [7:0]             mem_reg [`UECS_FIFO_DEPTH];
	logic [`UECS_PTR_W-1:0] wr_ptr_reg;
	logic [`UECS_PTR_W-1:0] rd_ptr_reg;
	logic [`UECS_CNT_W-1:0] cnt_reg;
	wire                    do_push;
	wire                    do_pop;

	// a push into a full fifo or a pop from an empty one is dropped
	assign do_push = push & ~full;
	assign do_pop  = pop & ~empty;
	assign full    = (cnt_reg == `UECS_CNT_FULL);
	assign empty   = (cnt_reg == '0);
	assign count   = cnt_reg;
	assign head    = mem_reg[rd_ptr_reg];

	// storage has no reset; only pointers and count are reset
	always_ff @(posedge core_clk) begin
		if (do_push) begin
			mem_reg[wr_ptr_reg] <= push_data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
		end else if (clr) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_reg <= wr_ptr_reg + `UECS_PTR_ONE;
			end
			if (do_pop) begin
				rd_ptr_reg <= rd_ptr_reg + `UECS_PTR_ONE;
			end
			if (do_push && !do_pop) begin
				cnt_reg <= cnt_reg + `UECS_CNT_ONE;
			end else if (do_pop && !do_push) begin
				cnt_reg <= cnt_reg - `UECS_CNT_ONE;
			end
		end
	end

endmodule : uecs_byte_fifo

// ===== rtl/uecs_endpoint.sv
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "uecs_consts.svh"

// Notes on behaviour
// - writing one forces stall replies, reads one
// - stall means request failed or endpoint halted
// - host stall acknowledge sets halt acked flag
// - bank1 stored sets flag; request while set
// - write zero frees bank1; one leaves it
// - direction bit: zero out, one in
// - status stage direction reversed by hardware
// - three-bit endpoint type encoding
// - read-only toggle shows DATA0 or DATA1
// - enable bit gates non-control endpoints only
// - reset leaves endpoint typed as control
// - eleven-bit count of bytes held
// - data register pops on read, pushes on write
// - transceiver off bit powers transceiver down
// - held single-ended zero treated as bus reset
// - setup flag set; out refused while set
module uecs_endpoint (
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rst_n,
	// register port
	input  wire logic [`UECS_ADDR_W-1:0]  reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [31:0]              reg_rdata,
	// packet engine
	input  wire uecs_pkg::uecs_evt_s      eng_evt,
	output uecs_pkg::uecs_rsp_s           eng_rsp,
	output logic                          rx_ready,
	output logic      [7:0]               tx_byte,
	output logic                          tx_valid,
	// transceiver and line
	input  wire logic                     line_se0,
	output logic                          xcvr_off,
	output logic                          usb_reset,
	// request line
	output logic                          ep_irq
);

	// stored control and status
	logic                 force_halt_bit_reg;
	logic                 halt_acked_flag_reg;
	logic                 rx_bank1_full_reg;
	logic                 setup_received_flag_reg;
	logic                 dir_reg;
	uecs_pkg::uecs_type_e endpoint_type_reg;
	logic                 toggle_state_reg;
	logic                 endpoint_enable_reg;
	logic                 transceiver_off_reg;
	logic [31:0]          rdata_reg;
	logic [31:0]          rdata_next;
	logic [7:0]           tx_byte_reg;
	logic [`UECS_SE0_W-1:0] se0_cnt_reg;
	logic                 usb_reset_reg;

	// decode
	wire sel_csr;
	wire sel_fdr;
	wire sel_txvc;
	wire wr_csr;
	wire wr_fdr;
	wire wr_txvc;
	wire rd_fdr;

	assign sel_csr  = (reg_addr == `UECS_OFS_CSR);
	assign sel_fdr  = (reg_addr == `UECS_OFS_FDR);
	assign sel_txvc = (reg_addr == `UECS_OFS_TXVC);
	assign wr_csr   = reg_wr & sel_csr;
	assign wr_fdr   = reg_wr & sel_fdr;
	assign wr_txvc  = reg_wr & sel_txvc;
	assign rd_fdr   = reg_rd & sel_fdr;

	// write data fields
	wire                 w_force;
	wire                 w_haltack;
	wire                 w_bk1;
	wire                 w_setup;
	wire                 w_dir;
	wire [2:0]           w_type;
	wire                 w_enable;
	wire                 w_xoff;

	assign w_force   = reg_wdata[`UECS_B_FORCE];
	assign w_haltack = reg_wdata[`UECS_B_HALTACK];
	assign w_bk1     = reg_wdata[`UECS_B_BK1];
	assign w_setup   = reg_wdata[`UECS_B_SETUP];
	assign w_dir     = reg_wdata[`UECS_B_DIR];
	assign w_type    = reg_wdata[`UECS_B_TYPE_HI:`UECS_B_TYPE_LO];
	assign w_enable  = reg_wdata[`UECS_B_ENABLE];
	assign w_xoff    = reg_wdata[`UECS_B_XOFF];

	// endpoint class from the type field
	wire is_ctrl;
	wire is_out_type;
	wire ep_active;

	assign is_ctrl     = (endpoint_type_reg == uecs_pkg::UECS_CTRL);
	// low two bits non-zero and top bit clear mark an out endpoint
	assign is_out_type = ~endpoint_type_reg[2] & (endpoint_type_reg[1:0] != 2'h0);
	// control endpoints run regardless of the enable bit
	assign ep_active   = is_ctrl | endpoint_enable_reg;

	// fifo hookup
	wire                   bus_reset_hit;
	wire                   fifo_push;
	wire [7:0]             fifo_push_data;
	wire                   fifo_pop;
	wire [7:0]             fifo_head;
	wire [`UECS_CNT_W-1:0] fifo_count;
	wire                   fifo_full;
	wire                   fifo_empty;

	// engine bytes win the write port; a firmware byte in the same cycle is lost
	assign fifo_push      = (eng_evt.rx_valid & ep_active) | wr_fdr;
	assign fifo_push_data = (eng_evt.rx_valid & ep_active) ? eng_evt.rx_byte : reg_wdata[`UECS_B_FDATA_HI:0];
	// one pop per cycle even if engine and firmware both drain
	assign fifo_pop       = rd_fdr | eng_evt.tx_pop;

	uecs_byte_fifo u_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.clr       (bus_reset_hit),
		.push      (fifo_push),
		.push_data (fifo_push_data),
		.pop       (fifo_pop),
		.head      (fifo_head),
		.count     (fifo_count),
		.full      (fifo_full),
		.empty     (fifo_empty)
	);

	// stall handshake selection
	wire stall_now;

	assign stall_now             = force_halt_bit_reg & ep_active;
	assign eng_rsp.send_stall    = stall_now;
	// control: request cannot complete; others: endpoint halted
	assign eng_rsp.stall_halted  = ~is_ctrl;

	// out data taken only when enabled, not stalled and no setup pending
	assign eng_rsp.out_accept    = ep_active & ~stall_now & ~setup_received_flag_reg & ~fifo_full
		& (is_ctrl ? (~dir_reg | eng_evt.status_stage) : is_out_type);

	// status stage reverses the programmed data stage direction
	assign eng_rsp.stage_dir_in  = eng_evt.status_stage ? ~dir_reg : dir_reg;
	// code 3'h4 is neither in nor out, so only true in codes pass here
	assign eng_rsp.in_allowed    = ep_active & ~stall_now & ~fifo_empty
		& (is_ctrl ? eng_rsp.stage_dir_in : (endpoint_type_reg[2] & (endpoint_type_reg[1:0] != 2'h0)));
	assign eng_rsp.ep_active     = ep_active;

	// back-pressure and transmit data
	assign rx_ready  = ~fifo_full;
	assign tx_byte   = tx_byte_reg;
	assign tx_valid  = ~fifo_empty & ep_active;

	// request line holds while any flag stays set
	assign ep_irq    = rx_bank1_full_reg | halt_acked_flag_reg | setup_received_flag_reg;

	// transceiver control and detected reset
	assign xcvr_off  = transceiver_off_reg;
	assign usb_reset = usb_reset_reg;
	assign reg_rdata = rdata_reg;

	// single-ended zero on floating or pulled-down lines counts as reset
	assign bus_reset_hit = (se0_cnt_reg == `UECS_SE0_W'(`UECS_SE0_CYC));

	// read data assembly, unmapped offsets read zero
	always_comb begin
		rdata_next = `UECS_RST_DATA;
		if (sel_csr) begin
			rdata_next[`UECS_B_SETUP]                   = setup_received_flag_reg;
			rdata_next[`UECS_B_HALTACK]                 = halt_acked_flag_reg;
			rdata_next[`UECS_B_FORCE]                   = force_halt_bit_reg;
			rdata_next[`UECS_B_BK1]                     = rx_bank1_full_reg;
			rdata_next[`UECS_B_DIR]                     = dir_reg;
			rdata_next[`UECS_B_TYPE_HI:`UECS_B_TYPE_LO] = endpoint_type_reg;
			rdata_next[`UECS_B_TOGGLE]                  = toggle_state_reg;
			// control endpoints always report enabled
			rdata_next[`UECS_B_ENABLE]                  = ep_active;
			rdata_next[`UECS_B_CNT_HI:`UECS_B_CNT_LO]   = fifo_count;
		end else if (sel_fdr) begin
			rdata_next[`UECS_B_FDATA_HI:0]              = fifo_empty ? 8'h00 : fifo_head;
		end else if (sel_txvc) begin
			rdata_next[`UECS_B_XOFF]                    = transceiver_off_reg;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= `UECS_RST_DATA;
		end else if (reg_rd) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= `UECS_RST_DATA;
		end
	end

	// transmit byte follows the fifo head; empty shows zero, not unwritten storage
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_byte_reg <= 8'h00;
		end else begin
			tx_byte_reg <= fifo_empty ? 8'h00 : fifo_head;
		end
	end

	// force stall: only firmware moves it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			force_halt_bit_reg <= `UECS_RST_BIT;
		end else if (wr_csr) begin
			force_halt_bit_reg <= w_force;
		end
	end

	// halt acknowledged: a new acknowledge beats a clearing write
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			halt_acked_flag_reg <= `UECS_RST_BIT;
		end else if (eng_evt.stall_acked && stall_now) begin
			halt_acked_flag_reg <= 1'h1;
		end else if (wr_csr && !w_haltack) begin
			halt_acked_flag_reg <= 1'h0;
		end
	end

	// bank-1 flag: zero releases the bank, one leaves it, set wins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_bank1_full_reg <= `UECS_RST_BIT;
		end else if (eng_evt.bk1_stored && ep_active) begin
			rx_bank1_full_reg <= 1'h1;
		end else if (wr_csr && !w_bk1) begin
			rx_bank1_full_reg <= 1'h0;
		end
	end

	// setup flag: valid setup sets it, firmware zero clears it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			setup_received_flag_reg <= `UECS_RST_BIT;
		end else if (eng_evt.setup_ok && is_ctrl) begin
			setup_received_flag_reg <= 1'h1;
		end else if (wr_csr && !w_setup) begin
			setup_received_flag_reg <= 1'h0;
		end
	end

	// direction and type are plain read-write fields; enable reads back as ep_active
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_reg             <= `UECS_RST_BIT;
			endpoint_type_reg   <= uecs_pkg::uecs_type_e'(`UECS_RST_TYPE);
			endpoint_enable_reg <= `UECS_RST_BIT;
		end else if (wr_csr) begin
			dir_reg             <= w_dir;
			// code 3'h4 is unused; it is stored but acts as neither in nor out
			endpoint_type_reg   <= uecs_pkg::uecs_type_e'(w_type);
			endpoint_enable_reg <= w_enable;
		end
	end

	// toggle follows the engine; bus reset restarts at DATA0
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			toggle_state_reg <= `UECS_RST_BIT;
		end else if (bus_reset_hit) begin
			toggle_state_reg <= 1'h0;
		end else if (eng_evt.toggle_upd) begin
			toggle_state_reg <= eng_evt.toggle_val;
		end
	end

	// transceiver off bit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			transceiver_off_reg <= `UECS_RST_BIT;
		end else if (wr_txvc) begin
			transceiver_off_reg <= w_xoff;
		end
	end

	// se0 length counter, saturates once reset is recognised
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			se0_cnt_reg <= '0;
		end else if (!line_se0 || transceiver_off_reg) begin
			se0_cnt_reg <= '0;
		end else if (!bus_reset_hit) begin
			se0_cnt_reg <= se0_cnt_reg + `UECS_SE0_W'(1);
		end
	end

	// one-cycle pulse when a bus reset is first seen
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			usb_reset_reg <= `UECS_RST_BIT;
		end else begin
			usb_reset_reg <= line_se0 & ~transceiver_off_reg
				& (se0_cnt_reg == `UECS_SE0_W'(`UECS_SE0_CYC - 1));
		end
	end

endmodule : uecs_endpoint

// ===== verif/uecs_endpoint_monitor.sv
`timescale 1ns/1ps
`include "uecs_consts.svh"

module uecs_endpoint_monitor (
	// clock and reset
	input wire logic                    core_clk,
	input wire logic                    rst_n,
	// register port
	input wire logic [`UECS_ADDR_W-1:0] reg_addr,
	input wire logic [31:0]             reg_wdata,
	input wire logic                    reg_wr,
	// engine and line
	input wire uecs_pkg::uecs_evt_s     eng_evt,
	input wire uecs_pkg::uecs_rsp_s     eng_rsp,
	input wire logic                    line_se0,
	input wire logic                    xcvr_off,
	input wire logic                    usb_reset,
	input wire logic                    ep_irq
);
	// shadows of writable csr fields, held se0 count
	logic [2:0] ty_reg;
	logic       dir_reg;
	logic       en_reg;
	logic [6:0] se0_reg;
	wire        csr_wr = reg_wr && reg_addr == `UECS_OFS_CSR;
	wire        txvc_wr = reg_wr && reg_addr == `UECS_OFS_TXVC;
	wire        wd_xoff = reg_wdata[`UECS_B_XOFF];
	wire        wd_halt = reg_wdata[`UECS_B_FORCE];
	wire [6:0]  se0_next = line_se0 ? se0_reg + {6'h00, se0_reg != 7'h7f} : 7'h00;

	// saturating, so a long se0 never wraps into a false match
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ty_reg <= 3'h0;
			dir_reg <= 1'h0;
			en_reg <= 1'h0;
			se0_reg <= 7'h00;
		end else begin
			if (csr_wr) begin
				ty_reg <= reg_wdata[`UECS_B_TYPE_HI:`UECS_B_TYPE_LO];
				dir_reg <= reg_wdata[`UECS_B_DIR];
				en_reg <= reg_wdata[`UECS_B_ENABLE];
			end
			se0_reg <= se0_next;
		end
	end

	default clocking mon_cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// stall follows the written bit and only a write ends it
	chk_stall_set: assert property (csr_wr && wd_halt |=> eng_rsp.send_stall)
		else $error("stall reply missing after force write");
	chk_stall_clr: assert property (csr_wr && !wd_halt |=> !eng_rsp.send_stall)
		else $error("stall reply still on after clear write");
	chk_stall_keeps: assert property (eng_rsp.send_stall && !csr_wr |=> eng_rsp.send_stall)
		else $error("stall dropped without a write");
	chk_halt_kind: assert property (
		eng_rsp.send_stall && (ty_reg == 3'h0 || ty_reg[1]) |-> eng_rsp.stall_halted == (ty_reg != 3'h0))
		else $error("stall meaning wrong for endpoint type");
	// status flags raise the request line; stage direction, enable, transceiver and bus reset checks follow
	chk_ack_flag: assert property (eng_evt.stall_acked && eng_rsp.send_stall |=> ep_irq)
		else $error("acked stall did not raise request");
	chk_bank1_irq: assert property (eng_evt.bk1_stored && eng_rsp.ep_active |=> ep_irq)
		else $error("bank1 store did not raise request");
	chk_setup_refuse: assert property (eng_evt.setup_ok && ty_reg == 3'h0 |=> !eng_rsp.out_accept && ep_irq)
		else $error("out accepted while setup pending");
	chk_stage_dir: assert property (eng_rsp.stage_dir_in == (eng_evt.status_stage ? !dir_reg : dir_reg))
		else $error("stage direction wrong");
	chk_ctrl_enable: assert property (eng_rsp.ep_active == (ty_reg == 3'h0 || en_reg))
		else $error("endpoint active state wrong");
	chk_xcvr_follow: assert property (txvc_wr |=> xcvr_off == $past(wd_xoff))
		else $error("transceiver state does not follow write");
	chk_bus_reset: assert property (usb_reset |-> se0_reg >= 7'h64 && se0_reg <= 7'h65)
		else $error("bus reset without a full se0 hold");

	cover property (usb_reset);
	cover property (eng_evt.stall_acked && eng_rsp.send_stall);
	cover property (eng_evt.setup_ok ##1 ep_irq);
endmodule : uecs_endpoint_monitor

bind uecs_endpoint uecs_endpoint_monitor u_mon (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
	.eng_evt, .eng_rsp, .line_se0, .xcvr_off, .usb_reset, .ep_irq);

// ===== verif/uecs_host_model.sv
`timescale 1ns/1ps

// packet engine stand-in; everything moves just after an edge
module uecs_host_model (
	// clock
	input  wire logic           core_clk,
	// engine events and line state
	output uecs_pkg::uecs_evt_s eng_evt,
	output logic                line_se0
);
	uecs_pkg::uecs_evt_s lv = '0;
	uecs_pkg::uecs_evt_s nx;

	initial begin
		eng_evt = '0;
		line_se0 = 1'b0;
	end

	// one-cycle event; released byte lane shows the inverse, not a stale copy
	task automatic pulse(input uecs_pkg::uecs_evt_s v);
		@(posedge core_clk);
		nx = v;
		nx.data_stage = lv.data_stage;
		nx.status_stage = lv.status_stage;
		eng_evt <= nx;
		@(posedge core_clk);
		lv.rx_byte = ~v.rx_byte;
		eng_evt <= lv;
	endtask : pulse

	// stage levels, held until changed
	task automatic stage(input logic ds, input logic ss);
		@(posedge core_clk);
		lv.data_stage = ds;
		lv.status_stage = ss;
		eng_evt <= lv;
	endtask : stage

	task automatic se0(input logic v);
		@(posedge core_clk);
		line_se0 <= v;
	endtask : se0
endmodule : uecs_host_model

// ===== verif/uecs_endpoint_tb_top.sv
`timescale 1ns/1ps
`include "uecs_consts.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; $display("ERROR %0t got %h want %h", $time, a, b); end end

module uecs_endpoint_tb_top;
	logic                    core_clk = 1'b0;
	logic                    rst_n = 1'b0;
	logic [`UECS_ADDR_W-1:0] reg_addr = 8'h00;
	logic [31:0]             reg_wdata = 32'h0000_0000;
	logic                    reg_wr = 1'b0;
	logic                    reg_rd = 1'b0;
	logic [31:0]             reg_rdata, d;
	uecs_pkg::uecs_evt_s     eng_evt;
	uecs_pkg::uecs_rsp_s     eng_rsp;
	logic                    rx_ready, tx_valid, line_se0, xcvr_off, usb_reset, ep_irq;
	logic [7:0]              tx_byte, eb;
	logic [15:0]             lfsr = 16'hddc7;
	int                      errors = 0;
	int                      num_checks = 0;
	int                      k;
	// reference model; codes: control, then out and in kinds
	int                      m_setup, m_hack, m_force, m_bk1, m_dir, m_ty, m_tog, m_en;
	logic [7:0]              q[$];
	int                      codes[7] = '{0, 1, 5, 2, 6, 3, 7};

	always #12.5 core_clk = ~core_clk;

	uecs_endpoint DUT (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .eng_evt,
		.eng_rsp, .rx_ready, .tx_byte, .tx_valid, .line_se0, .xcvr_off, .usb_reset, .ep_irq);
	uecs_host_model host (.core_clk, .eng_evt, .line_se0);

	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction : rnd

	function automatic logic act();
		return m_ty == 0 || m_en != 0;
	endfunction : act

	function automatic logic [31:0] csr_exp();
		return {5'h00, 11'(q.size()), act(), 3'h0, m_tog[0], m_ty[2:0], m_dir[0], m_bk1[0], m_force[0], 1'b0,
			m_hack[0], m_setup[0], 2'h0};
	endfunction : csr_exp

	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		if (a == `UECS_OFS_CSR) begin
			m_setup &= v[2];
			m_hack &= v[3];
			m_bk1 &= v[6];
			m_force = v[5];
			m_dir = v[7];
			m_ty = v[10:8];
			m_en = v[15];
		end
		if (a == `UECS_OFS_FDR && q.size() < `UECS_FIFO_DEPTH) q.push_back(v[7:0]);
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
		if (a == `UECS_OFS_FDR && q.size() > 0) void'(q.pop_front());
	endtask : rd

	task automatic csr_ok();
		rd(`UECS_OFS_CSR, d);
		`CHK(d, csr_exp())
	endtask : csr_ok

	// keep holds flag bits at one so they are not cleared
	task automatic csrw(input int f, dr, ty, en, input logic [31:0] keep);
		wr(`UECS_OFS_CSR, keep | 32'(en << 15 | ty << 8 | dr << 7 | f << 5));
	endtask : csrw

	// engine event: 0 setup, 1 bank1, 2 stall ack, 3 toggle, 4 byte, 5 pop
	task automatic ev(input int f, input logic [7:0] b);
		uecs_pkg::uecs_evt_s v;
		v = '0;
		case (f)
			0: v.setup_ok = 1'b1;
			1: v.bk1_stored = 1'b1;
			2: v.stall_acked = 1'b1;
			3: v.toggle_upd = 1'b1;
			4: v.rx_valid = 1'b1;
			default: v.tx_pop = 1'b1;
		endcase
		v.toggle_val = b[0];
		v.rx_byte = b;
		host.pulse(v);
		if (f == 0 && m_ty == 0) m_setup = 1;
		if (f == 1 && act()) m_bk1 = 1;
		if (f == 2 && m_force != 0) m_hack = 1;
		if (f == 3) m_tog = b[0];
		if (f == 4 && act() && q.size() < `UECS_FIFO_DEPTH) q.push_back(b);
		if (f == 5 && q.size() > 0) void'(q.pop_front());
		#1;
	endtask : ev

	initial begin
		#500000;
		errors++;
		end_sim();
	end

	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		csr_ok();
		rd(`UECS_OFS_TXVC, d);
		`CHK(d, 32'h0000_0000)
		rd(8'h0c, d);
		`CHK(d, 32'h0000_0000)
		$display("test reset done");
		// every type code, disabled and then enabled
		for (int e = 0; e < 2; e++) begin
			foreach (codes[i]) begin
				csrw(0, 0, codes[i], e, 32'h0);
				csr_ok();
				`CHK(eng_rsp.ep_active, codes[i] == 0 || e == 1)
			end
		end
		$display("test types done");
		// forced stall on bulk then control, acked, held until written off
		for (int t = 0; t < 2; t++) begin
			csrw(1, 0, t ? 0 : 6, 1, 32'h0);
			`CHK(eng_rsp.send_stall, 1'b1)
			`CHK(eng_rsp.stall_halted, t == 0)
			ev(2, 8'h00);
			repeat (30) @(posedge core_clk);
			csr_ok();
			`CHK(ep_irq, 1'b1)
			csrw(0, 0, 0, 1, 32'h44);
			csr_ok();
		end
		$display("test stall done");
		// setup holds off data out; direction set before the flag is freed
		ev(0, 8'h00);
		`CHK(eng_rsp.out_accept, 1'b0)
		csrw(0, 1, 0, 0, 32'h4c);
		csrw(0, 1, 0, 0, 32'h48);
		csr_ok();
		for (int s = 0; s < 2; s++) begin
			host.stage(1'b1, s[0]);
			#1;
			`CHK(eng_rsp.stage_dir_in, s == 0)
			`CHK(eng_rsp.out_accept, s == 1)
		end
		host.stage(1'b0, 1'b0);
		ev(3, 8'h01);
		csr_ok();
		$display("test control done");
		// host fills the memory to the brim, firmware drains it
		csrw(0, 0, 2, 1, 32'h0);
		repeat (`UECS_FIFO_DEPTH) ev(4, rnd());
		`CHK(rx_ready, 1'b0)
		ev(1, 8'h00);
		csr_ok();
		`CHK(ep_irq, 1'b1)
		while (q.size() > 0) begin
			eb = q[0];
			rd(`UECS_OFS_FDR, d);
			`CHK(d, {24'h000000, eb})
		end
		csrw(0, 0, 2, 1, 32'h40);
		csr_ok();
		csrw(0, 0, 2, 1, 32'h0);
		csr_ok();
		`CHK(ep_irq, 1'b0)
		$display("test bank1 done");
		// firmware loads a short packet, host takes it byte by byte
		csrw(0, 0, 6, 1, 32'h0);
		repeat (3) @(posedge core_clk);
		repeat (8) wr(`UECS_OFS_FDR, {rnd(), rnd(), rnd(), rnd()});
		csr_ok();
		`CHK(eng_rsp.in_allowed, 1'b1)
		`CHK(tx_valid, 1'b1)
		`CHK(tx_byte, q[0])
		repeat (8) ev(5, 8'h00);
		`CHK(tx_valid, 1'b0)
		`CHK(eng_rsp.in_allowed, 1'b0)
		$display("test fifo done");
		// transceiver power, then a held se0 flushes and clears toggle
		wr(`UECS_OFS_TXVC, 32'h0000_0100);
		`CHK(xcvr_off, 1'b1)
		rd(`UECS_OFS_TXVC, d);
		`CHK(d, 32'h0000_0100)
		wr(`UECS_OFS_TXVC, 32'h0000_0000);
		`CHK(xcvr_off, 1'b0)
		repeat (2) wr(`UECS_OFS_FDR, 32'h0000_00a5);
		host.se0(1'b1);
		k = 0;
		while (usb_reset !== 1'b1 && k < 150) begin
			@(posedge core_clk);
			#1;
			k++;
		end
		`CHK(k, 100)
		if (k == 150) end_sim();
		host.se0(1'b0);
		q.delete();
		m_tog = 0;
		csr_ok();
		$display("test line done");
		end_sim();
	end
endmodule : uecs_endpoint_tb_top
